// ==== verilog/hrs_pkg.sv ====
/*
 Shared constants and types for the homing retry sequencer.
 Assumes a 100 MHz hclk and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package hrs_pkg;
    // timing
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned TICK_CYC = MS_NS / CLK_NS;
    // register byte offsets
    localparam logic [7:0] R_CTRL = 8'h00;
    localparam logic [7:0] R_PARAM = 8'h04;
    localparam logic [7:0] R_SPEED = 8'h08;
    localparam logic [7:0] R_STAT = 8'h0c;
    localparam logic [7:0] R_ACT = 8'h10;
    // control fields
    localparam int C_START = 0;
    localparam int C_READY = 1;
    localparam int C_DIR = 2;
    localparam int C_METH = 4;
    // parameter and speed fields
    localparam int P_RETRY = 0;
    localparam int P_DWELL = 16;
    localparam int S_HOME = 0;
    localparam int S_CREEP = 16;
    // status fields
    localparam int T_BUSY = 0;
    localparam int T_DONE = 1;
    localparam int T_ERR = 2;
    localparam int T_ZSEEN = 3;
    localparam int T_STATE = 8;
    localparam int T_CODE = 16;
    // reset values
    localparam logic RETRY_RST = 1'b0;
    localparam logic [15:0] DWELL_RST = 16'h0000;
    localparam logic [15:0] SPEED_RST = 16'h0000;
    localparam logic [2:0] METH_RST = 3'h0;
    // homing methods
    localparam logic [2:0] M_DOG = 3'h0;
    localparam logic [2:0] M_DOG2 = 3'h1;
    localparam logic [2:0] M_CNT1 = 3'h2;
    localparam logic [2:0] M_CNT2 = 3'h3;
    localparam logic [2:0] M_CNT3 = 3'h4;
    localparam logic [2:0] M_DATA = 3'h5;
    // error codes
    localparam logic [7:0] E_NONE = 8'h00;
    localparam logic [7:0] E_NOZERO = 8'hd2;
    localparam logic [7:0] E_LIMIT = 8'h01;

    typedef enum logic [3:0] {
        ST_IDLE, ST_SEARCH, ST_CREEP, ST_ZSTOP, ST_DOGSTOP, ST_NPFWD,
        ST_LIMSTOP, ST_DWELL_A, ST_REV, ST_REVSTOP, ST_DWELL_B, ST_ERRSTOP
    } hrs_state_t;

    function automatic logic is_dog(input logic [2:0] m);
        return (m == M_DOG) || (m == M_DOG2);
    endfunction

    function automatic logic retry_ok(input logic [2:0] m);
        return is_dog(m) || (m == M_CNT1) || (m == M_CNT2) || (m == M_CNT3);
    endfunction
endpackage
`default_nettype wire

// ==== verilog/hrs_ahb_slave.sv ====
/*
 AHB-Lite slave front end: zero wait states, OKAY always.
 Assumes one master; register decode and read mux sit in the parent.
*/
`timescale 1ns/100ps
`default_nettype none
module hrs_ahb_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data
);
    logic acc;
    logic wpend_q, wpend_d;
    logic [7:0] waddr_q, waddr_d;
    logic [31:0] rdata_q, rdata_d;

    // address phase: only word transfers are decoded
    always_comb
    begin
        acc = hsel && hready && htrans[1] && (hsize == 3'h2);
        wpend_d = acc && hwrite;
        waddr_d = acc ? haddr[7:0] : waddr_q;
        rdata_d = (acc && !hwrite) ? rd_data : 32'h0000_0000;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wpend_q <= 1'b0;
            waddr_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wpend_q <= wpend_d;
            waddr_q <= waddr_d;
            rdata_q <= rdata_d;
        end
    end

    // read data sampled in the address phase, so a read right after a
    // write to the same word returns the old value
    assign rd_addr = haddr[7:0];
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_en = wpend_q;
    assign wr_addr = waddr_q;
    assign wr_data = hwdata;
endmodule
`default_nettype wire

// ==== verilog/hrs_dwell_timer.sv ====
/*
 Millisecond dwell down-counter for retry reversals.
 Assumes load is a one-cycle pulse from the sequencer.
*/
`timescale 1ns/100ps
`default_nettype none
module hrs_dwell_timer #(
    parameter int unsigned TICKS = hrs_pkg::TICK_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic load,
    input wire logic [15:0] dwell_ms,
    output logic expired
);
    localparam int PW = $clog2(TICKS + 1);
    localparam logic [PW-1:0] PMAX = PW'(TICKS - 1);
    logic [PW-1:0] pre_q, pre_d;
    logic [15:0] cnt_q, cnt_d;
    logic tick;

    // prescaler restarts at load so each ms is a full one
    always_comb
    begin
        tick = (pre_q == '0);
        pre_d = (load || tick) ? PMAX : pre_q - PW'(1);
        cnt_d = cnt_q;
        if (load)
            cnt_d = dwell_ms;
        else if (tick && cnt_q != 16'h0000)
            cnt_d = cnt_q - 16'h0001;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre_q <= '0;
            cnt_q <= 16'h0000;
        end
        else
        begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    assign expired = (cnt_q == 16'h0000);

    AST_DWELL_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !load && !tick |=> $stable(cnt_q))
        else $error("dwell count moved without a tick");
endmodule
`default_nettype wire

// ==== verilog/hrs_axis.sv ====
/*
 One-axis homing sequencer with limit-switch retry and register file.
 Assumes limit inputs high while inside the stroke, dog high on the dog,
 a one-cycle zero pulse, and a motion profile that reports standstill.
*/
// Functional notes
// - start command moves axis in the homing direction
// - with retry, a limit going OFF starts a deceleration stop
// - after limit stop, run at homing speed opposite to homing direction
// - reverse run stops at dog OFF, then homing restarts
// - stop at zero point completes homing
// - dog ON drops speed from homing to creep speed
// - zero not passed: stop at dog OFF, continue forward at homing speed; here dog methods only, count methods 2 and 3 keep creeping
// - then stop at limit OFF, reverse, stop at dog OFF, repeat
// - same dwell before reverse run and before re-homing
// - retry for dog and count methods, never for data setting
// - first count method, no zero before dog OFF: stop, error 210
// - second dog method with retry: no zero triggers retry sequence
// - legacy variant, basic dog method: error 210 instead of retry
// - retry search runs until a hardware limit is seen
// - retry enabled only when parameter is 1, reset value 0
// - dwell 0 to 65535 ms, reset value 0
// - retry parameters take effect on ready rising edge, per axis
`timescale 1ns/100ps
`default_nettype none
module hrs_axis #(
    parameter int unsigned TICKS = hrs_pkg::TICK_CYC,
    parameter bit LEGACY = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic limit_upper,
    input wire logic limit_lower,
    input wire logic dog,
    input wire logic zero_pulse,
    input wire logic motion_stopped,
    output logic drive_run,
    output logic drive_fwd,
    output logic [15:0] drive_speed
);
    logic [7:0] rd_addr, wr_addr;
    logic [31:0] rd_data, wr_data;
    logic wr_en, expired, dwell_load;
    // software-facing settings
    logic ready_q, ready_d, dir_q, dir_d, rst_q, rst_d, ract_q, ract_d;
    logic [2:0] meth_q, meth_d;
    logic [15:0] dst_q, dst_d, dact_q, dact_d;
    logic [15:0] hspd_q, hspd_d, cspd_q, cspd_d;
    logic start;
    // sequencer
    hrs_pkg::hrs_state_t st_q, st_d;
    logic dog_q, zs_q, zs_d, done_q, done_d, err_q, err_d;
    logic [7:0] code_q, code_d;
    logic run_d, fwd_d;
    logic [15:0] spd_d;
    logic home_fwd, lim_hit, dog_fall, retry_on;

    hrs_ahb_slave u_bus (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rd_addr(rd_addr), .rd_data(rd_data),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data)
    );

    hrs_dwell_timer #(.TICKS(TICKS)) u_dwell (
        .hclk(hclk), .hresetn(hresetn), .load(dwell_load),
        .dwell_ms(dact_q), .expired(expired)
    );

    // register writes; retry settings staged until ready rises
    always_comb
    begin
        ready_d = ready_q;
        dir_d = dir_q;
        meth_d = meth_q;
        rst_d = rst_q;
        dst_d = dst_q;
        hspd_d = hspd_q;
        cspd_d = cspd_q;
        start = 1'b0;
        if (wr_en && wr_addr == hrs_pkg::R_CTRL)
        begin
            ready_d = wr_data[hrs_pkg::C_READY];
            dir_d = wr_data[hrs_pkg::C_DIR];
            meth_d = wr_data[hrs_pkg::C_METH +: 3];
            start = wr_data[hrs_pkg::C_START] && ready_q;
        end
        if (wr_en && wr_addr == hrs_pkg::R_PARAM)
        begin
            rst_d = wr_data[hrs_pkg::P_RETRY];
            dst_d = wr_data[hrs_pkg::P_DWELL +: 16];
        end
        if (wr_en && wr_addr == hrs_pkg::R_SPEED)
        begin
            hspd_d = wr_data[hrs_pkg::S_HOME +: 16];
            cspd_d = wr_data[hrs_pkg::S_CREEP +: 16];
        end
        ract_d = (ready_d && !ready_q) ? rst_q : ract_q;
        dact_d = (ready_d && !ready_q) ? dst_q : dact_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ready_q <= 1'b0;
            dir_q <= 1'b0;
            meth_q <= hrs_pkg::METH_RST;
            rst_q <= hrs_pkg::RETRY_RST;
            ract_q <= hrs_pkg::RETRY_RST;
            dst_q <= hrs_pkg::DWELL_RST;
            dact_q <= hrs_pkg::DWELL_RST;
            hspd_q <= hrs_pkg::SPEED_RST;
            cspd_q <= hrs_pkg::SPEED_RST;
        end
        else
        begin
            ready_q <= ready_d;
            dir_q <= dir_d;
            meth_q <= meth_d;
            rst_q <= rst_d;
            ract_q <= ract_d;
            dst_q <= dst_d;
            dact_q <= dact_d;
            hspd_q <= hspd_d;
            cspd_q <= cspd_d;
        end
    end

    // read mux; unmapped words read zero
    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            hrs_pkg::R_CTRL:
            begin
                rd_data[hrs_pkg::C_READY] = ready_q;
                rd_data[hrs_pkg::C_DIR] = dir_q;
                rd_data[hrs_pkg::C_METH +: 3] = meth_q;
            end
            hrs_pkg::R_PARAM:
            begin
                rd_data[hrs_pkg::P_RETRY] = rst_q;
                rd_data[hrs_pkg::P_DWELL +: 16] = dst_q;
            end
            hrs_pkg::R_SPEED: rd_data = {cspd_q, hspd_q};
            hrs_pkg::R_STAT:
            begin
                rd_data[hrs_pkg::T_BUSY] = (st_q != hrs_pkg::ST_IDLE);
                rd_data[hrs_pkg::T_DONE] = done_q;
                rd_data[hrs_pkg::T_ERR] = err_q;
                rd_data[hrs_pkg::T_ZSEEN] = zs_q;
                rd_data[hrs_pkg::T_STATE +: 4] = st_q;
                rd_data[hrs_pkg::T_CODE +: 8] = code_q;
            end
            hrs_pkg::R_ACT:
            begin
                rd_data[hrs_pkg::P_RETRY] = ract_q;
                rd_data[hrs_pkg::P_DWELL +: 16] = dact_q;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // motion direction and event decode
    // start word may carry a new direction, so look at the written value
    assign home_fwd = !dir_d;
    assign lim_hit = drive_fwd ? !limit_upper : !limit_lower;
    assign dog_fall = dog_q && !dog;
    assign retry_on = ract_q && hrs_pkg::retry_ok(meth_q);

    // sequencer next state; in creep zero pulse beats limit beats dog edge, in reverse dog edge beats limit
    always_comb
    begin
        st_d = st_q;
        zs_d = zs_q || zero_pulse;
        done_d = done_q;
        err_d = err_q;
        code_d = code_q;
        dwell_load = 1'b0;
        case (st_q)
            hrs_pkg::ST_IDLE:
                if (start)
                begin
                    // method comes from the start word itself
                    zs_d = zero_pulse;
                    done_d = (meth_d == hrs_pkg::M_DATA);
                    err_d = 1'b0;
                    code_d = hrs_pkg::E_NONE;
                    if (meth_d != hrs_pkg::M_DATA)
                        st_d = hrs_pkg::ST_SEARCH;
                end
            hrs_pkg::ST_SEARCH:
                if (lim_hit)
                    st_d = retry_on ? hrs_pkg::ST_LIMSTOP
                                    : hrs_pkg::ST_ERRSTOP;
                else if (dog)
                    st_d = hrs_pkg::ST_CREEP;
            hrs_pkg::ST_CREEP:
                if (zero_pulse)
                    st_d = hrs_pkg::ST_ZSTOP;
                else if (lim_hit)
                    st_d = retry_on ? hrs_pkg::ST_LIMSTOP
                                    : hrs_pkg::ST_ERRSTOP;
                else if (dog_fall && !zs_q)
                begin
                    if (meth_q == hrs_pkg::M_CNT1 || !retry_on ||
                        (LEGACY && meth_q == hrs_pkg::M_DOG))
                    begin
                        st_d = hrs_pkg::ST_ERRSTOP;
                        code_d = hrs_pkg::E_NOZERO;
                    end
                    else if (hrs_pkg::is_dog(meth_q))
                        st_d = hrs_pkg::ST_DOGSTOP;
                end
            hrs_pkg::ST_ZSTOP:
                if (motion_stopped)
                begin
                    st_d = hrs_pkg::ST_IDLE;
                    done_d = 1'b1;
                end
            hrs_pkg::ST_DOGSTOP:
                if (motion_stopped)
                    st_d = hrs_pkg::ST_NPFWD;
            hrs_pkg::ST_NPFWD:
                // no timeout: only a limit ends this search
                if (lim_hit)
                    st_d = hrs_pkg::ST_LIMSTOP;
            hrs_pkg::ST_LIMSTOP:
                if (motion_stopped)
                begin
                    st_d = hrs_pkg::ST_DWELL_A;
                    dwell_load = 1'b1;
                end
            hrs_pkg::ST_DWELL_A:
                if (expired)
                    st_d = hrs_pkg::ST_REV;
            hrs_pkg::ST_REV:
                if (dog_fall)
                    st_d = hrs_pkg::ST_REVSTOP;
                else if (lim_hit)
                begin
                    st_d = hrs_pkg::ST_ERRSTOP;
                    code_d = hrs_pkg::E_LIMIT;
                end
            hrs_pkg::ST_REVSTOP:
                if (motion_stopped)
                begin
                    st_d = hrs_pkg::ST_DWELL_B;
                    dwell_load = 1'b1;
                end
            hrs_pkg::ST_DWELL_B:
                if (expired)
                begin
                    st_d = hrs_pkg::ST_SEARCH;
                    zs_d = zero_pulse; // a mark in this cycle still counts
                end
            hrs_pkg::ST_ERRSTOP:
                if (motion_stopped)
                begin
                    st_d = hrs_pkg::ST_IDLE;
                    err_d = 1'b1;
                    if (code_q == hrs_pkg::E_NONE)
                        code_d = hrs_pkg::E_LIMIT;
                end
            default: st_d = hrs_pkg::ST_IDLE;
        endcase
        // drive command follows the next state; stops hold dir and speed
        run_d = 1'b0;
        fwd_d = drive_fwd;
        spd_d = drive_speed;
        case (st_d)
            hrs_pkg::ST_SEARCH, hrs_pkg::ST_NPFWD:
            begin
                run_d = 1'b1;
                fwd_d = home_fwd;
                spd_d = hspd_q;
            end
            hrs_pkg::ST_CREEP:
            begin
                run_d = 1'b1;
                fwd_d = home_fwd;
                spd_d = cspd_q;
            end
            hrs_pkg::ST_REV:
            begin
                run_d = 1'b1;
                fwd_d = !home_fwd;
                spd_d = hspd_q;
            end
            default: run_d = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q <= hrs_pkg::ST_IDLE;
            dog_q <= 1'b0;
            zs_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            code_q <= hrs_pkg::E_NONE;
            drive_run <= 1'b0;
            drive_fwd <= 1'b1;
            drive_speed <= 16'h0000;
        end
        else
        begin
            st_q <= st_d;
            dog_q <= dog;
            zs_q <= zs_d;
            done_q <= done_d;
            err_q <= err_d;
            code_q <= code_d;
            drive_run <= run_d;
            drive_fwd <= fwd_d;
            drive_speed <= spd_d;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_START_MOVES: assert property (
        st_q == hrs_pkg::ST_IDLE && start && meth_d != hrs_pkg::M_DATA
        |=> drive_run && drive_fwd == home_fwd)
        else $error("start did not move toward home");
    AST_LIMIT_STOP: assert property (
        st_q == hrs_pkg::ST_SEARCH && lim_hit && retry_on
        |=> !drive_run && st_q == hrs_pkg::ST_LIMSTOP)
        else $error("limit did not stop the search");
    AST_REV_RUN: assert property (
        st_q == hrs_pkg::ST_REV
        |-> drive_run && drive_fwd != home_fwd && drive_speed == hspd_q)
        else $error("reverse run wrong direction or speed");
    AST_REV_DOG: assert property (
        st_q == hrs_pkg::ST_REV && dog_fall
        |=> !drive_run ##1 st_q == hrs_pkg::ST_REVSTOP || motion_stopped)
        else $error("dog off did not stop reverse run");
    AST_ZERO_DONE: assert property (
        st_q == hrs_pkg::ST_ZSTOP && motion_stopped
        |=> done_q && !drive_run && st_q == hrs_pkg::ST_IDLE)
        else $error("zero point stop did not complete");
    AST_CREEP: assert property (
        st_q == hrs_pkg::ST_SEARCH && dog && !lim_hit
        |=> drive_speed == cspd_q)
        else $error("dog on did not select creep speed");
    AST_DOGSTOP_FWD: assert property (
        st_q == hrs_pkg::ST_DOGSTOP && motion_stopped
        |=> drive_run && drive_fwd == home_fwd && drive_speed == hspd_q)
        else $error("no forward run after dog stop");
    AST_NPFWD_LIM: assert property (
        st_q == hrs_pkg::ST_NPFWD && lim_hit
        |=> st_q == hrs_pkg::ST_LIMSTOP)
        else $error("forward search ignored the limit");
    AST_DWELL_ZERO: assert property (
        st_q == hrs_pkg::ST_LIMSTOP && motion_stopped && dact_q == 16'h0000
        |=> st_q == hrs_pkg::ST_DWELL_A ##1 st_q == hrs_pkg::ST_REV)
        else $error("zero dwell did not pass in one cycle");
    AST_DATA_IDLE: assert property (
        meth_d == hrs_pkg::M_DATA && st_q == hrs_pkg::ST_IDLE
        |=> st_q == hrs_pkg::ST_IDLE)
        else $error("data setting method started motion");
    AST_CNT1_ERR: assert property (
        st_q == hrs_pkg::ST_CREEP && meth_q == hrs_pkg::M_CNT1 &&
        dog_fall && !zs_q && !zero_pulse && !lim_hit
        |=> st_q == hrs_pkg::ST_ERRSTOP && code_q == 8'hd2)
        else $error("missing not-passed error");
    AST_DOG2_RETRY: assert property (
        st_q == hrs_pkg::ST_CREEP && meth_q == hrs_pkg::M_DOG2 && retry_on &&
        dog_fall && !zs_q && !zero_pulse && !lim_hit
        |=> st_q == hrs_pkg::ST_DOGSTOP)
        else $error("second dog method did not retry");
    AST_LEGACY: assert property (
        LEGACY && st_q == hrs_pkg::ST_CREEP && meth_q == hrs_pkg::M_DOG &&
        dog_fall && !zs_q && !zero_pulse && !lim_hit
        |=> st_q == hrs_pkg::ST_ERRSTOP)
        else $error("legacy variant retried");
    AST_SEARCH_RUNS: assert property (
        st_q == hrs_pkg::ST_NPFWD && !lim_hit |=> drive_run)
        else $error("forward search stopped without a limit");
    AST_NO_RETRY: assert property (
        !ract_q && st_q == hrs_pkg::ST_SEARCH && lim_hit
        |=> st_q == hrs_pkg::ST_ERRSTOP)
        else $error("retry ran while disabled");
    AST_CAPTURE: assert property (
        !(ready_d && !ready_q) |=> $stable(ract_q) && $stable(dact_q))
        else $error("retry settings changed without ready edge");
    COV_RETRY: cover property (st_q == hrs_pkg::ST_REV ##[1:1000]
        st_q == hrs_pkg::ST_SEARCH);
    COV_NOTPASS: cover property (st_q == hrs_pkg::ST_NPFWD);
    COV_DONE: cover property (st_q == hrs_pkg::ST_ZSTOP ##1 done_q);
endmodule
`default_nettype wire

// ==== sim/hrs_motor_model.sv ====
/*
 Axis model: stroke switches, near-point dog and zero mark on a track.
 Assumes the drive moves one position per clock while it runs.
*/
`timescale 1ns/100ps
`default_nettype none
module hrs_motor_model (
    input wire logic hclk,
    input wire logic drive_run,
    input wire logic drive_fwd,
    input wire logic no_zero,
    output logic limit_upper,
    output logic limit_lower,
    output logic dog,
    output logic zero_pulse,
    output var logic motion_stopped
);
    int pos = 50;
    // standstill shows one edge after run drops
    always @(posedge hclk)
    begin
        motion_stopped <= !drive_run;
        if (drive_run)
            pos <= drive_fwd ? pos + 1 : pos - 1;
    end
    // both switches wired; open at the track ends
    assign limit_upper = pos < 200;
    assign limit_lower = pos > 0;
    assign dog = pos >= 100 && pos <= 120;
    // zero mark can be hidden to force the not-passed path
    assign zero_pulse = drive_run && pos == 110 && !no_zero;
endmodule
`default_nettype wire

// ==== sim/homing_retry_sequencer_bench.sv ====
/*
 Bench for one homing axis: bus tasks, motor model, queued read checks.
 Assumes zero wait states and ten cycles per millisecond tick.
*/
`timescale 1ns/100ps
`default_nettype none
module homing_retry_sequencer_bench;
    logic hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0, no_zero = 1'h0;
    logic rd_dp = 1'h0, saw_rev = 1'h0, saw_cr = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, lfsr = 32'hf3f1, v, p;
    logic hreadyout, hresp, lu, ll, dg, zp, ms, run, fwd;
    logic [15:0] spd;
    logic [31:0] exp_q[$], msk_q[$];
    int n_errors = 0, checks_done = 0;
    logic [2:0] tm[6] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h5, 3'h3};
    int tp[6] = '{50, 150, 50, 50, 50, 150};
    logic tz[6] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0};
    always #5 hclk = !hclk;
    hrs_motor_model mdl (.hclk(hclk), .drive_run(run), .drive_fwd(fwd),
        .no_zero(no_zero), .limit_upper(lu), .limit_lower(ll), .dog(dg),
        .zero_pulse(zp), .motion_stopped(ms));
    hrs_axis #(.TICKS(10)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .limit_upper(lu),
        .limit_lower(ll), .dog(dg), .zero_pulse(zp), .motion_stopped(ms),
        .drive_run(run), .drive_fwd(fwd), .drive_speed(spd));
    function automatic logic [31:0] nx(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] ex);
        checks_done++;
        if (seen !== ex)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // bounded wait for hready; a hang ends the run
    task automatic hs();
        int i;
        for (i = 0; i < 50; i++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'h1)
                break;
        end
        if (i == 50)
        begin
            n_errors++;
            stop_test();
        end
    endtask
    // one single word transfer, read data left in v
    task automatic bus(logic [7:0] a, logic w, logic [31:0] d, logic nt);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hs();
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !w && nt;
        hs();
        v = hrdata;
        rd_dp <= 1'h0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(a, 1'h0, 32'h0, 1'h1);
    endtask
    // poll status until the axis is no longer busy
    task automatic idle();
        int i;
        for (i = 0; i < 600; i++)
        begin
            bus(hrs_pkg::R_STAT, 1'h0, 32'h0, 1'h0);
            if (v[hrs_pkg::T_BUSY] === 1'h0)
                break;
        end
        if (i == 600)
        begin
            n_errors++;
            stop_test();
        end
    endtask
    // oldest note against data-phase read data
    always @(posedge hclk)
        if (rd_dp && exp_q.size() > 0)
        begin
            chk("rdata", hrdata & msk_q.pop_front(), exp_q.pop_front());
            chk("hresp", hresp, 32'h0);
        end
    // reversal at homing speed lets the hidden zero mark come back
    always @(posedge hclk)
    begin
        if (run && !fwd && spd === p[15:0])
        begin
            saw_rev <= 1'h1;
            no_zero <= 1'h0;
        end
        if (run && spd === ~p[15:0])
            saw_cr <= 1'h1;
    end
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        rd(hrs_pkg::R_PARAM, 32'h0, '1);
        rd(hrs_pkg::R_ACT, 32'h0, '1);
        rd(8'h20, 32'h0, '1);
        lfsr = nx(lfsr);
        p = {14'h0, lfsr[17:16], 16'h1};
        bus(hrs_pkg::R_PARAM, 1'h1, p, 1'h0);
        p[15:0] = lfsr[15:0] | 16'h1;
        bus(hrs_pkg::R_SPEED, 1'h1, {~p[15:0], p[15:0]}, 1'h0);
        rd(hrs_pkg::R_ACT, 32'h0, '1);
        bus(hrs_pkg::R_CTRL, 1'h1, 32'h2, 1'h0);
        rd(hrs_pkg::R_ACT, {14'h0, lfsr[17:16], 16'h1}, '1);
        // methods, start positions and hidden zero marks
        for (int i = 0; i < 6; i++)
        begin
            // last run recaptured with zero dwell: reversals skip the wait
            if (i == 5)
            begin
                bus(hrs_pkg::R_PARAM, 1'h1, 32'h1, 1'h0);
                bus(hrs_pkg::R_CTRL, 1'h1, 32'h0, 1'h0);
                bus(hrs_pkg::R_CTRL, 1'h1, 32'h2, 1'h0);
                rd(hrs_pkg::R_ACT, 32'h1, '1);
            end
            mdl.pos <= tp[i];
            no_zero <= tz[i];
            saw_rev <= 1'h0;
            saw_cr <= 1'h0;
            bus(hrs_pkg::R_CTRL, 1'h1, {25'h0, tm[i], 4'h3}, 1'h0);
            idle();
            if (i == 3)
                rd(hrs_pkg::R_STAT, 32'hd20004, 32'hff0005);
            else
                rd(hrs_pkg::R_STAT, 32'h2, 32'hff0007);
            chk("rev", saw_rev, i == 1 || i == 2 || i == 5);
            chk("creep", saw_cr, i != 4);
            $display("test %0d finished", i);
        end
        stop_test();
    end
endmodule
`default_nettype wire
